// ==== i2cst_top.sv ====
// Status, mode and timeout control of the two-wire interface with APB access
//
// Behaviour
// - Busy bus with clock line high past the selected period sets the timeout flag.
// - Setting the timeout flag also pulses the interrupt request in the same step.
// - Timeout length and flag act only while timeout is enabled; flag is read-only.
// - Timeout counts bit clock ticks: 65536 long, 16384 short.
// - Timeout flag clears only on interface disable or soft reset write.
// - Upper divider: 000 uses lower field, 001 divides 2.5, 100 divides 6.
// - Upper 010 divides 3, 011 divides 5; lower 00/01/10 divide 2/4/8.
// - Multi-address select picks slave address 0 only, or addresses 0 to 2.
// - Stop detected with stop interrupt enabled sets stop request; only writing 0 clears.
// - That stop event also pulses the interrupt request.
// - Low six status bits are hardware-owned; full writes trigger start or stop.
// - Code E0 arms start standby, C0 arms stop standby; low bits untouched.
// - Low nibble 1111 with pending 0 updates only master and transmit bits.
// - Last bit is the ack level, or last data bit without ack clock; data write clears.
// - General call flag sets on address zero in slave mode; clears on start/stop/disable.
// - Address match sets in slave receive on match or general call; clears on data write.
// - Arbitration lost sets on foreign low data line or start overlap; clears on data write.
// - Status reads pending low-active, busy, transmit and master bits.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "i2cst_cfg.svh"
module i2cst_top
	import i2cst_pkg::*;
#(
	parameter int TIMEOUT_LONG_CYCLES  = `I2CST_TO_LONG,
	parameter int TIMEOUT_SHORT_CYCLES = `I2CST_TO_SHORT
)(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Bus line levels
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	// Shift engine events
	input  wire logic        addr_valid_in,
	input  wire logic [6:0]  addr_in,
	input  wire logic        addr_rw_in,
	input  wire logic        byte_end_in,
	input  wire logic        ack_end_in,
	input  wire logic        nack_slave_in,
	input  wire logic        master_sending_in,
	input  wire logic        sda_drive_high_in,
	input  wire logic        ack_phase_in,
	input  wire logic        overlap_in,
	input  wire logic        arb_byte_done_in,
	input  wire logic        data_write_in,
	// Outputs to engine and interrupt controller
	output logic             start_standby_out,
	output logic             stop_standby_out,
	output logic             irq_request_out,
	output logic             bit_clock_en_out,
	output logic             bus_busy_out,
	output logic             master_out,
	output logic             transmit_out,
	output logic             ack_clock_enable_out,
	output logic             free_format_out
);
	localparam logic [16:0] TO_LONG_M1  = 17'(TIMEOUT_LONG_CYCLES - 1);
	localparam logic [16:0] TO_SHORT_M1 = 17'(TIMEOUT_SHORT_CYCLES - 1);
	localparam logic [7:0]  C2_RST      = `I2CST_C2_RESET;
	localparam logic [7:0]  C1_RST      = `I2CST_C1_RESET;
	localparam logic [7:0]  ST_RST      = `I2CST_STAT_RESET;

	if (TIMEOUT_LONG_CYCLES < 2 || TIMEOUT_LONG_CYCLES > 65536 ||
		TIMEOUT_SHORT_CYCLES < 2 || TIMEOUT_SHORT_CYCLES > TIMEOUT_LONG_CYCLES) begin : g_chk
		$error("timeout lengths out of range");
	end

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic        toe_q, tof_q, timeout_length_select_q, multi_address_select_q, stop_irq_request_q;
	logic [2:0]  upper_q;
	logic        en_q, free_q, sim_q, ack_clock_enable_q;
	logic [1:0]  lower_q;
	logic [6:0]  sad_q [3];
	logic        mst_q, trx_q, bb_q, pin_q, al_q, aas_q, gc_q, lrb_q;
	logic [16:0] cnt_q;
	logic        sda_q;
	logic        irq_q, start_sb_q, stop_sb_q;
	logic [31:0] prdata_q;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic [9:0]   idx;
	logic         hit_c2, hit_st, hit_c1, hit_sad;
	logic         wr, wr_c2, wr_st, wr_c1;
	logic [1:0]   sad_sel;
	i2cst_byte_t  wb;
	i2cst_wcode_e wcode;

	assign idx     = paddr_in[11:2];
	assign hit_c2  = idx == `I2CST_IDX_CTRL2;
	assign hit_st  = idx == `I2CST_IDX_STAT0;
	assign hit_c1  = idx == `I2CST_IDX_CTRL1;
	assign hit_sad = idx >= `I2CST_IDX_SAD0 && idx <= `I2CST_IDX_SAD2;
	assign sad_sel = 2'(idx - `I2CST_IDX_SAD0);
	assign wb      = pwdata_in[7:0];
	assign wr      = psel_in && penable_in && pwrite_in;
	assign wr_c2   = wr && hit_c2;
	assign wr_st   = wr && hit_st;
	assign wr_c1   = wr && hit_c1;

	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !(hit_c2 || hit_st || hit_c1 || hit_sad);
	assign prdata_out  = prdata_q;

	// Only the documented codes act; any other value is ignored
	always_comb begin
		wcode = I2CST_WC_NONE;
		if (wr_st) begin
			if (wb == `I2CST_W_START)
				wcode = I2CST_WC_START;
			else if (wb == `I2CST_W_STOP)
				wcode = I2CST_WC_STOP;
			else if ((wb & `I2CST_W_MODE_MASK) == `I2CST_W_MODE_CODE)
				wcode = I2CST_WC_MODE;
		end
	end

	// ---------------------------------------------------------------
	// Line events and shared conditions
	// ---------------------------------------------------------------
	logic clear_all, start_det, stop_det, tick, tof_set, stop_req_set;
	logic addr_slave, gc_hit, match_hit, al_set, pin_set;
	logic trx_hwclr, mst_hwclr;

	assign clear_all = wr_c1 && (!wb[`I2CST_C1_EN] || wb[`I2CST_C1_SRST]);
	assign start_det = en_q && scl_in && sda_q && !sda_in;
	assign stop_det  = en_q && scl_in && !sda_q && sda_in;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			sda_q <= 1'b1;
		else
			sda_q <= sda_in;
	end

	i2cst_clkdiv u_div (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (en_q),
		.upper_in   (upper_q),
		.lower_in   (lower_q),
		.tick_out   (tick)
	);

	// ---------------------------------------------------------------
	// Timeout detection
	// ---------------------------------------------------------------
	logic [16:0] to_lim;
	assign to_lim  = timeout_length_select_q ? TO_SHORT_M1 : TO_LONG_M1;
	assign tof_set = toe_q && bb_q && scl_in && tick && cnt_q == to_lim;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cnt_q <= 17'h00000;
		else if (!toe_q || !scl_in || !bb_q)
			cnt_q <= 17'h00000;
		else if (tick && cnt_q != to_lim)
			cnt_q <= cnt_q + 17'h00001;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tof_q <= 1'b0;
		else if (tof_set)
			tof_q <= 1'b1;
		else if (clear_all)
			tof_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	assign stop_req_set = stop_det && sim_q;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{stop_irq_request_q, multi_address_select_q, upper_q, timeout_length_select_q, toe_q} <= {C2_RST[7:2], C2_RST[0]};
		end else if (wr_c2) begin
			toe_q   <= wb[`I2CST_C2_TOE];
			timeout_length_select_q <= wb[`I2CST_C2_TIMEOUT_LENGTH_SELECT];
			upper_q <= wb[`I2CST_C2_UPPER_LO +: 3];
			multi_address_select_q <= wb[`I2CST_C2_MULTI_ADDRESS_SELECT];
			stop_irq_request_q <= stop_req_set || (stop_irq_request_q && wb[`I2CST_C2_STOP_IRQ_REQUEST]);
		end else if (stop_req_set) begin
			stop_irq_request_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{lower_q, ack_clock_enable_q, sim_q, free_q, en_q} <= {C1_RST[6:2], C1_RST[0]};
		end else if (wr_c1) begin
			en_q     <= wb[`I2CST_C1_EN];
			free_q   <= wb[`I2CST_C1_FREE];
			sim_q    <= wb[`I2CST_C1_SIM];
			ack_clock_enable_q <= wb[`I2CST_C1_ACK_CLOCK_ENABLE];
			lower_q  <= wb[`I2CST_C1_LOWER_LO +: 2];
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sad_q[0] <= 7'h00;
			sad_q[1] <= 7'h00;
			sad_q[2] <= 7'h00;
		end else if (wr && hit_sad) begin
			sad_q[sad_sel] <= wb[6:0];
		end
	end

	// ---------------------------------------------------------------
	// Address matching and status flags
	// ---------------------------------------------------------------
	assign addr_slave = addr_valid_in && !mst_q && !free_q;
	assign gc_hit     = addr_slave && addr_in == 7'h00;
	assign match_hit  = addr_slave && !trx_q && (addr_in == sad_q[0] || gc_hit ||
		(multi_address_select_q && (addr_in == sad_q[1] || addr_in == sad_q[2])));
	assign al_set     = (master_sending_in && !ack_phase_in && sda_drive_high_in && !sda_in)
		|| overlap_in;
	assign pin_set    = (ack_clock_enable_q ? ack_end_in : byte_end_in) || match_hit || gc_hit
		|| (addr_valid_in && !mst_q && free_q);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			lrb_q <= ST_RST[0];
		else if (ack_clock_enable_q ? ack_end_in : byte_end_in)
			lrb_q <= sda_in;
		else if (data_write_in || clear_all)
			lrb_q <= 1'b0;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			gc_q <= ST_RST[1];
		else if (gc_hit)
			gc_q <= 1'b1;
		else if (start_det || stop_det || clear_all)
			gc_q <= 1'b0;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			aas_q <= ST_RST[2];
		else if (match_hit)
			aas_q <= 1'b1;
		else if (data_write_in || clear_all)
			aas_q <= 1'b0;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			al_q <= ST_RST[3];
		else if (al_set)
			al_q <= 1'b1;
		else if (data_write_in || clear_all)
			al_q <= 1'b0;
	end

	// Pending is low-active: zero means an interrupt is requested
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			pin_q <= ST_RST[4];
		else if (pin_set)
			pin_q <= 1'b0;
		else if (data_write_in || clear_all)
			pin_q <= 1'b1;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			bb_q <= ST_RST[5];
		else if (start_det)
			bb_q <= 1'b1;
		else if (stop_det || clear_all)
			bb_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Mode bits; hardware clears win over a software mode write
	// ---------------------------------------------------------------
	assign trx_hwclr = al_set || stop_det || overlap_in || clear_all
		|| (start_det && !mst_q) || (nack_slave_in && !mst_q);
	assign mst_hwclr = (arb_byte_done_in && al_q) || stop_det || overlap_in || clear_all;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			trx_q <= ST_RST[6];
		else if (trx_hwclr)
			trx_q <= 1'b0;
		else if (wcode != I2CST_WC_NONE)
			trx_q <= wb[6];
		else if (match_hit && addr_rw_in)
			trx_q <= 1'b1;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			mst_q <= ST_RST[7];
		else if (mst_hwclr)
			mst_q <= 1'b0;
		else if (wcode != I2CST_WC_NONE)
			mst_q <= wb[7];
	end

	// ---------------------------------------------------------------
	// Pulses and read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_q      <= 1'b0;
			start_sb_q <= 1'b0;
			stop_sb_q  <= 1'b0;
		end else begin
			// Counter saturates while the line stays high; request only when the flag rises
			irq_q      <= (tof_set && !tof_q) || stop_req_set || (pin_set && pin_q);
			start_sb_q <= wcode == I2CST_WC_START;
			stop_sb_q  <= wcode == I2CST_WC_STOP;
		end
	end

	// Read data is captured in the setup phase and shown in the access phase
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			prdata_q <= 32'h00000000;
		else if (psel_in && !penable_in) begin
			prdata_q <= 32'h00000000;
			if (hit_c2)
				prdata_q[7:0] <= {stop_irq_request_q, multi_address_select_q, upper_q, timeout_length_select_q, tof_q, toe_q};
			else if (hit_st)
				prdata_q[7:0] <= {mst_q, trx_q, bb_q, pin_q, al_q, aas_q, gc_q, lrb_q};
			else if (hit_c1)
				prdata_q[7:0] <= {1'b0, lower_q, ack_clock_enable_q, sim_q, free_q, 1'b0, en_q};
			else if (hit_sad)
				prdata_q[6:0] <= sad_q[sad_sel];
		end
	end

	assign start_standby_out    = start_sb_q;
	assign stop_standby_out     = stop_sb_q;
	assign irq_request_out      = irq_q;
	assign bit_clock_en_out     = tick;
	assign bus_busy_out         = bb_q;
	assign master_out           = mst_q;
	assign transmit_out         = trx_q;
	assign ack_clock_enable_out = ack_clock_enable_q;
	assign free_format_out      = free_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_addr_gc;
		gc_hit && !start_det && !stop_det && !clear_all;
	endsequence
	sequence s_mode_write;
		wcode == I2CST_WC_MODE && !trx_hwclr && !mst_hwclr && !start_det && !stop_det;
	endsequence

	property p_tof_set;
		@(posedge clk_in) disable iff (sys_rst_in)
		toe_q && bb_q && scl_in && tick && cnt_q == to_lim |=> tof_q;
	endproperty
	a_tof_set: assert property (p_tof_set) else $error("timeout flag not set");

	property p_tof_irq;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(tof_q) |-> irq_request_out;
	endproperty
	a_tof_irq: assert property (p_tof_irq) else $error("timeout without irq");

	property p_tof_ro;
		@(posedge clk_in) disable iff (sys_rst_in)
		tof_q && wr_c2 && !wb[`I2CST_C2_TOF] && !clear_all |=> tof_q;
	endproperty
	a_tof_ro: assert property (p_tof_ro) else $error("timeout flag written");

	property p_tof_clr;
		@(posedge clk_in) disable iff (sys_rst_in)
		clear_all && !tof_set |=> !tof_q ##1 (!tof_q || $past(tof_set));
	endproperty
	a_tof_clr: assert property (p_tof_clr) else $error("timeout flag not cleared");

	property p_cnt_rst;
		@(posedge clk_in) disable iff (sys_rst_in)
		!scl_in || !bb_q |=> cnt_q == 17'h00000;
	endproperty
	a_cnt_rst: assert property (p_cnt_rst) else $error("timeout counter not restarted");

	property p_stop_irq_request_w1;
		@(posedge clk_in) disable iff (sys_rst_in)
		!stop_irq_request_q && wr_c2 && wb[`I2CST_C2_STOP_IRQ_REQUEST] && !stop_req_set |=> !stop_irq_request_q;
	endproperty
	a_stop_irq_request_w1: assert property (p_stop_irq_request_w1) else $error("stop request set by write");

	property p_stop_irq;
		@(posedge clk_in) disable iff (sys_rst_in)
		stop_det && sim_q |=> stop_irq_request_q && irq_request_out;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("stop request missing");

	property p_start_code;
		@(posedge clk_in) disable iff (sys_rst_in)
		wr_st && wb == `I2CST_W_START |=> start_standby_out && !stop_standby_out ##1 !start_standby_out;
	endproperty
	a_start_code: assert property (p_start_code) else $error("start standby wrong");

	property p_mode;
		@(posedge clk_in) disable iff (sys_rst_in)
		s_mode_write |=> mst_q == $past(wb[7]) && trx_q == $past(wb[6]) && $stable(bb_q);
	endproperty
	a_mode: assert property (p_mode) else $error("mode bits not updated");

	property p_gc;
		@(posedge clk_in) disable iff (sys_rst_in)
		s_addr_gc |=> gc_q && !pin_q;
	endproperty
	a_gc: assert property (p_gc) else $error("general call not flagged");
endmodule

// ==== i2cst_cfg.svh ====
// Register indices, field positions, reset values and divider counts
`ifndef I2CST_CFG_SVH
`define I2CST_CFG_SVH

// Register indices; byte address is four times the index
`define I2CST_IDX_CTRL2      10'h2B7
`define I2CST_IDX_STAT0      10'h2B8
`define I2CST_IDX_CTRL1      10'h2B0
`define I2CST_IDX_SAD0       10'h2B1
`define I2CST_IDX_SAD1       10'h2B2
`define I2CST_IDX_SAD2       10'h2B3

// Timeout/clock control fields
`define I2CST_C2_TOE         0
`define I2CST_C2_TOF         1
`define I2CST_C2_TIMEOUT_LENGTH_SELECT       2
`define I2CST_C2_UPPER_LO    3
`define I2CST_C2_MULTI_ADDRESS_SELECT       6
`define I2CST_C2_STOP_IRQ_REQUEST       7
`define I2CST_C2_RESET       8'h00

// Interface control fields
`define I2CST_C1_EN          0
`define I2CST_C1_SRST        1
`define I2CST_C1_FREE        2
`define I2CST_C1_SIM         3
`define I2CST_C1_ACK_CLOCK_ENABLE      4
`define I2CST_C1_LOWER_LO    5
`define I2CST_C1_RESET       8'h00

// Status write codes
`define I2CST_W_START        8'hE0
`define I2CST_W_STOP         8'hC0
`define I2CST_W_MODE_MASK    8'h1F
`define I2CST_W_MODE_CODE    8'h0F
`define I2CST_STAT_RESET     8'h10

// Divider thresholds: twice the division ratio
`define I2CST_THR_DIV2       5'h04
`define I2CST_THR_DIV4       5'h08
`define I2CST_THR_DIV8       5'h10
`define I2CST_THR_DIV2P5     5'h05
`define I2CST_THR_DIV3       5'h06
`define I2CST_THR_DIV5       5'h0A
`define I2CST_THR_DIV6       5'h0C
`define I2CST_ACC_STEP       5'h02

// Timeout lengths in bit clock cycles
`define I2CST_TO_LONG        65536
`define I2CST_TO_SHORT       16384

`endif

// ==== i2cst_pkg.sv ====
// Shared types of the status and timeout block
package i2cst_pkg;
	typedef logic [7:0] i2cst_byte_t;
	typedef enum logic [1:0] {
		I2CST_WC_NONE,
		I2CST_WC_START,
		I2CST_WC_STOP,
		I2CST_WC_MODE
	} i2cst_wcode_e;
endpackage

// ==== i2cst_clkdiv.sv ====
// Fractional divider that makes the bit clock enable from the module clock
`timescale 1ns/1ps
`include "i2cst_cfg.svh"
module i2cst_clkdiv
	import i2cst_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// Control
	input  wire logic       run_in,
	input  wire logic [2:0] upper_in,
	input  wire logic [1:0] lower_in,
	// Enable pulse
	output logic            tick_out
);
	logic [4:0] acc_q;
	logic [4:0] thr;
	logic [4:0] sum;

	function automatic logic [4:0] div_thr(input logic [2:0] up, input logic [1:0] lo);
		logic [4:0] t;
		t = `I2CST_THR_DIV2;
		case (up)
			3'h0: begin
				case (lo)
					2'h1:    t = `I2CST_THR_DIV4;
					2'h2:    t = `I2CST_THR_DIV8;
					default: t = `I2CST_THR_DIV2;
				endcase
			end
			3'h1:    t = `I2CST_THR_DIV2P5;
			3'h2:    t = `I2CST_THR_DIV3;
			3'h3:    t = `I2CST_THR_DIV5;
			3'h4:    t = `I2CST_THR_DIV6;
			default: t = `I2CST_THR_DIV2;
		endcase
		return t;
	endfunction

	// Adds two per cycle against twice the ratio, so 2.5 alternates 2 and 3
	assign thr = div_thr(upper_in, lower_in);
	assign sum = acc_q + `I2CST_ACC_STEP;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			acc_q    <= 5'h00;
			tick_out <= 1'b0;
		end else if (!run_in) begin
			acc_q    <= 5'h00;
			tick_out <= 1'b0;
		end else if (sum >= thr) begin
			acc_q    <= sum - thr;
			tick_out <= 1'b1;
		end else begin
			acc_q    <= sum;
			tick_out <= 1'b0;
		end
	end
endmodule

// ==== i2cst_peer.sv ====
// Far-side bus party that drives the clock and data line levels
`timescale 1ns/1ps
module i2cst_peer (
	// Clock
	input  wire logic clk_in,
	// Line levels, pulled up when idle
	output logic      scl_out,
	output logic      sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Sets both lines after an edge and holds them
	task automatic lines(input logic s, input logic d);
		@(posedge clk_in);
		scl_out <= s;
		sda_out <= d;
		repeat (3) @(posedge clk_in);
	endtask
	// Data falls while the clock is high
	task automatic start_cond();
		lines(1'b1, 1'b1);
		lines(1'b1, 1'b0);
	endtask
	// Data rises while the clock is high
	task automatic stop_cond();
		lines(1'b0, 1'b0);
		lines(1'b1, 1'b0);
		lines(1'b1, 1'b1);
	endtask
endmodule

// ==== i2c_status_timeout_control_tb.sv ====
// Self-checking bench for the status, mode and timeout block
`timescale 1ns/1ps
`include "i2cst_cfg.svh"
module i2c_status_timeout_control_tb;
	import i2cst_pkg::*;
	localparam logic [9:0] IC1 = `I2CST_IDX_CTRL1;
	localparam logic [9:0] IC2 = `I2CST_IDX_CTRL2;
	localparam logic [9:0] IST = `I2CST_IDX_STAT0;
	localparam int         L_N = 64;
	localparam int         S_N = 16;
	logic        clk_in, sys_rst_in, psel, pen, pwr, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic        pready, pslverr, scl, sda, rw, msend, drvh, ackph;
	logic        ss, sp, irq, tick, busy, master_select, transmit_select, ackc, frf;
	logic [6:0]  addr, a;
	logic [5:0]  low;
	logic [4:0]  ev;
	int          fail_count, compares, irq_n, ss_n, sp_n, n, k, lim;
	int          thr[7] = '{4, 8, 16, 5, 6, 10, 12};

	i2cst_top #(.TIMEOUT_LONG_CYCLES(L_N), .TIMEOUT_SHORT_CYCLES(S_N)) i_dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda),
		.addr_valid_in(ev[0]), .addr_in(addr), .addr_rw_in(rw), .byte_end_in(ev[4]),
		.ack_end_in(ev[1]), .nack_slave_in(1'b0), .master_sending_in(msend),
		.sda_drive_high_in(drvh), .ack_phase_in(ackph), .overlap_in(ev[3]),
		.arb_byte_done_in(1'b0), .data_write_in(ev[2]), .start_standby_out(ss),
		.stop_standby_out(sp), .irq_request_out(irq), .bit_clock_en_out(tick),
		.bus_busy_out(busy), .master_out(master_select), .transmit_out(transmit_select),
		.ack_clock_enable_out(ackc), .free_format_out(frf));
	i2cst_peer i_peer (.clk_in(clk_in), .scl_out(scl), .sda_out(sda));

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Counts one-cycle pulses mid-cycle, where they are settled
	always @(negedge clk_in) begin
		if (irq === 1'b1) irq_n <= irq_n + 1;
		if (ss === 1'b1) ss_n <= ss_n + 1;
		if (sp === 1'b1) sp_n <= sp_n + 1;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		print_verdict();
	end

	// ----------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= {i, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge clk_in);
		pen <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [7:0] m, input string nm);
		apb(1'b0, i, 8'h00);
		chk(nm, {24'h000000, e & m}, r & {24'h000000, m});
	endtask
	task automatic ticks(input int t);
		repeat (t) do @(posedge clk_in); while (tick !== 1'b1);
	endtask
	task automatic pulse(input int b);
		ev[b] <= 1'b1;
		@(posedge clk_in);
		ev <= 5'h00;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(89036));
		{sys_rst_in, psel, pen, pwr, paddr, pwdata} = {1'b1, 47'h0};
		{rw, msend, drvh, ackph, addr, ev} = 16'h0000;
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		rd(IC2, 8'h00, 8'hFF, "control two reset");
		rd(IST, 8'h10, 8'hFF, "status reset");
		apb(1'b1, 10'h3FF, 8'h5A);
		chk("unmapped error", 32'h1, 32'(slv));
		for (int c = 0; c < 7; c++) begin
			apb(1'b1, IC1, 8'h00);
			apb(1'b1, IC2, (c < 3) ? 8'h00 : 8'((c - 2) << 3));
			apb(1'b1, IC1, (c < 3) ? 8'((c << 5) | 1) : 8'h01);
			ticks(1);
			n = 0;
			repeat (12) do begin
				@(posedge clk_in);
				n++;
			end while (tick !== 1'b1);
			chk("divider span", 32'(6 * thr[c]), 32'(n));
		end
		for (int s = 0; s < 2; s++) begin
			lim = s ? S_N : L_N;
			apb(1'b1, IC1, 8'h00);
			apb(1'b1, IC2, 8'(1 | (s << 2)));
			apb(1'b1, IC1, 8'h01);
			i_peer.start_cond();
			chk("busy", 32'h1, 32'(busy));
			ticks(lim / 2);
			i_peer.lines(1'b0, 1'b0);
			i_peer.lines(1'b1, 1'b0);
			ticks(lim - 6);
			rd(IC2, 8'h00, 8'h02, "timeout early");
			k = irq_n;
			ticks(12);
			rd(IC2, 8'h02, 8'h02, "timeout set");
			chk("timeout irq", 32'(k + 1), 32'(irq_n));
			apb(1'b1, IC2, 8'(1 | (s << 2)));
			rd(IC2, 8'h02, 8'h02, "timeout kept");
			// Clock low stops the timeout before the interface is disabled
			i_peer.lines(1'b0, 1'b1);
		end
		apb(1'b1, IC1, 8'h00);
		rd(IC2, 8'h00, 8'h02, "timeout cleared");
		apb(1'b1, IC1, 8'h09);
		i_peer.start_cond();
		k = irq_n;
		i_peer.stop_cond();
		chk("stop irq", 32'(k + 1), 32'(irq_n));
		rd(IC2, 8'h80, 8'h80, "stop request");
		apb(1'b1, IC2, 8'h80);
		rd(IC2, 8'h80, 8'h80, "stop kept");
		apb(1'b1, IC2, 8'h00);
		rd(IC2, 8'h00, 8'h80, "stop cleared");
		apb(1'b0, IST, 8'h00);
		low = r[5:0];
		apb(1'b1, IST, 8'hE0);
		chk("start standby", 32'h1, 32'(ss_n));
		chk("start mode", 32'h3, 32'({master_select, transmit_select}));
		apb(1'b1, IST, 8'hC0);
		chk("stop standby", 32'h1, 32'(sp_n));
		rd(IST, {2'h3, low}, 8'hFF, "stop write");
		repeat (6) begin
			v = $urandom;
			apb(1'b1, IST, {v[1:0], v[2], 5'h0F});
			rd(IST, {v[1:0], low}, 8'hFF, "mode write");
			apb(1'b1, IST, {~v[1:0], 6'h3F});
			rd(IST, {v[1:0], low}, 8'hFF, "refused write");
		end
		chk("standby count", 32'h1, 32'(ss_n));
		apb(1'b1, IST, 8'h0F);
		a = 7'($urandom_range(126, 1));
		apb(1'b1, `I2CST_IDX_SAD0, 8'h7F);
		apb(1'b1, `I2CST_IDX_SAD1, {1'h0, a});
		addr <= a;
		pulse(0);
		rd(IST, 8'h00, 8'h04, "single match");
		apb(1'b1, IC2, 8'h40);
		pulse(0);
		rd(IST, 8'h04, 8'h04, "multi match");
		pulse(2);
		rd(IST, 8'h00, 8'h04, "match cleared");
		addr <= 7'h00;
		pulse(0);
		rd(IST, 8'h06, 8'h06, "general call");
		i_peer.start_cond();
		rd(IST, 8'h00, 8'h02, "general cleared");
		apb(1'b1, IC1, 8'h11);
		chk("ack clock out", 32'h1, 32'(ackc));
		i_peer.lines(1'b0, 1'b1);
		pulse(1);
		rd(IST, 8'h01, 8'h01, "no ack");
		pulse(2);
		rd(IST, 8'h00, 8'h01, "last bit cleared");
		apb(1'b1, IST, 8'hCF);
		msend <= 1'b1;
		drvh <= 1'b1;
		i_peer.lines(1'b0, 1'b0);
		msend <= 1'b0;
		rd(IST, 8'h08, 8'h08, "arbitration lost");
		pulse(2);
		rd(IST, 8'h00, 8'h08, "arbitration cleared");
		pulse(3);
		rd(IST, 8'h08, 8'h08, "overlap lost");
		apb(1'b1, IC1, 8'h04);
		chk("free format", 32'h1, 32'(frf));
		apb(1'b1, IC1, 8'h00);
		rd(IST, 8'h10, 8'hFE, "disabled status");
		print_verdict();
	end
endmodule
